// ---- bench/test_playback_protection_config_bank.sv ----
// self-checking bench for the playback protection configuration bank
`timescale 1ns/1ps
`default_nettype none
module test_playback_protection_config_bank;
   logic mclk, nrst, regWrite, regRead, attnPin, sarValid, clockErrorEvt, pllLockEvt;
   logic [7:0] regAddr, regWdata, regRdata, sarSample, mixEnables, featureEnables;
   logic limiterActive, supplySampleToDsp, playbackShutdown, irqOut;
   logic [2:0] appliedAttn;
   int errors = 0;
   int checks = 0;
   logic [7:0] ofsTab [5] = '{8'h2b, 8'h2c, 8'h2d, 8'h2e, 8'h2f};
   logic [7:0] onesTab [5] = '{8'hfc, 8'hf0, 8'hef, 8'hff, 8'hc0};

   ppc_config_bank #(.SAR_W(8)) uut (.mclk(mclk), .nrst(nrst), .regWrite(regWrite),
      .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
      .attnPin(attnPin), .sarSample(sarSample), .sarValid(sarValid),
      .clockErrorEvt(clockErrorEvt), .pllLockEvt(pllLockEvt), .limiterActive(limiterActive),
      .appliedAttn(appliedAttn), .mixEnables(mixEnables), .featureEnables(featureEnables),
      .supplySampleToDsp(supplySampleToDsp), .playbackShutdown(playbackShutdown),
      .irqOut(irqOut));

   // ---------------------------------------------------------------
   // clock, shared tasks
   // ---------------------------------------------------------------
   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task automatic give_verdict();
      if (errors == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp)
      begin
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         errors++;
      end
   endtask

   // every drive lands 1 ns after a rising edge
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   // trailing idle cycle keeps regWrite from toggling twice in one step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      regAddr = a;
      regWdata = d;
      regWrite = 1'b1;
      tick(1);
      regWrite = 1'b0;
      tick(1);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      regAddr = a;
      regRead = 1'b1;
      tick(1);
      regRead = 1'b0;
      tick(1);
      check(regRdata, exp);
   endtask

   task automatic sar(input logic [7:0] s);
      sarSample = s;
      sarValid = 1'b1;
      tick(1);
      sarValid = 1'b0;
      tick(10);
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic test_reset_values();
      for (int i = 0; i < 5; i++)
         rd(ofsTab[i], (i == 3) ? 8'hbf : ((i == 4) ? 8'hc0 : 8'h00));
      rd(ppc_pkg::OFS_LATCH0, 8'h00);
      rd(8'h30, 8'h00);
      check({mixEnables[7:4], featureEnables[7:4]}, 8'h00);
      check({4'h0, limiterActive, playbackShutdown, irqOut, supplySampleToDsp}, 8'h00);
   endtask

   task automatic test_write_all_ones();
      for (int i = 0; i < 5; i++)
      begin
         // all writable bits set, reserved bits kept at their reset value
         wr(ofsTab[i], onesTab[i]);
         rd(ofsTab[i], onesTab[i]);
      end
      tick(2);
      check(mixEnables, 8'hf0);
      check(featureEnables, 8'hef);
      check({7'h00, supplySampleToDsp}, 8'h01);
      wr(8'h30, 8'hff);
      rd(8'h30, 8'h00);
   endtask

   task automatic test_pin_limiter();
      // level left from the all-ones pass never drops without recovery, so clear it
      wr(ppc_pkg::OFS_LIMITER, 8'h00);
      attnPin = 1'b1;
      wr(ppc_pkg::OFS_LIMITER, 8'hd0);
      tick(10);
      check({limiterActive, 4'h0, appliedAttn}, 8'h85);
      attnPin = 1'b0;
      tick(10);
      check({5'h00, appliedAttn}, 8'h05);
      wr(ppc_pkg::OFS_LIMITER, 8'hd4);
      tick(10);
      check({5'h00, appliedAttn}, 8'h00);
      attnPin = 1'b1;
      tick(10);
      check({5'h00, appliedAttn}, 8'h05);
      wr(ppc_pkg::OFS_LIMITER, 8'h54);
      tick(10);
      check({limiterActive, 4'h0, appliedAttn}, 8'h00);
      attnPin = 1'b0;
   endtask

   task automatic test_analog_limiter();
      wr(ppc_pkg::OFS_LIMITER, 8'h8c);
      sar(8'h40);
      check({5'h00, appliedAttn}, 8'h05);
      sar(8'ha0);
      check({5'h00, appliedAttn}, 8'h02);
      wr(ppc_pkg::OFS_LIMITER, 8'h88);
      sar(8'he0);
      check({5'h00, appliedAttn}, 8'h02);
   endtask

   task automatic test_undervoltage();
      wr(ppc_pkg::OFS_UVTHR, 8'h80);
      wr(ppc_pkg::OFS_FEATURE, 8'h02);
      sar(8'h10);
      check({7'h00, playbackShutdown}, 8'h00);
      wr(ppc_pkg::OFS_FEATURE, 8'h03);
      sar(8'h7f);
      check({7'h00, playbackShutdown}, 8'h01);
      sar(8'h80);
      check({7'h00, playbackShutdown}, 8'h00);
   endtask

   task automatic test_events();
      clockErrorEvt = 1'b1;
      tick(1);
      clockErrorEvt = 1'b0;
      tick(2);
      check({7'h00, irqOut}, 8'h00);
      rd(ppc_pkg::OFS_LATCH0, 8'h80);
      rd(ppc_pkg::OFS_LATCH0, 8'h00);
      wr(ppc_pkg::OFS_MASK0, 8'h00);
      pllLockEvt = 1'b1;
      tick(1);
      pllLockEvt = 1'b0;
      tick(1);
      check({7'h00, irqOut}, 8'h01);
      rd(ppc_pkg::OFS_LATCH0, 8'h40);
      tick(1);
      check({7'h00, irqOut}, 8'h00);
   endtask

   // ---------------------------------------------------------------
   // main sequence and watchdog
   // ---------------------------------------------------------------
   initial
   begin
      nrst = 1'b0;
      {regWrite, regRead, attnPin, sarValid, clockErrorEvt, pllLockEvt} = 6'h00;
      regAddr = 8'h00;
      regWdata = 8'h00;
      sarSample = 8'hff;
      repeat (4) @(posedge mclk);
      #1;
      nrst = 1'b1;
      tick(1);
      test_reset_values();
      test_write_all_ones();
      test_pin_limiter();
      test_analog_limiter();
      test_undervoltage();
      test_events();
      give_verdict();
   end

   // whole run is well under a thousand cycles
   initial
   begin
      #50000;
      errors++;
      give_verdict();
   end
endmodule
`default_nettype wire

// ---- verilog/ppc_attn_if.sv ----
// ppc_attn_if: attenuation request and applied level between top and tracker
`timescale 1ns/1ps
`default_nettype none
interface ppc_attn_if;
   logic enable;
   logic recover;
   logic release_req;
   logic [2:0] target;
   logic [2:0] level;
   modport ctl (output enable, output recover, output release_req, output target, input level);
   modport trk (input enable, input recover, input release_req, input target, output level);
endinterface
`default_nettype wire

// ---- verilog/ppc_attn_track.sv ----
// ppc_attn_track: applied attenuation level with optional recovery
`timescale 1ns/1ps
`default_nettype none
module ppc_attn_track
(
   input wire logic mclk,
   input wire logic nrst,
   ppc_attn_if.trk att
);
   logic [2:0] level_reg;
   logic [2:0] level_next;
   wire logic raise = att.target > level_reg;
   wire logic lower = att.recover && att.release_req && (att.target < level_reg);

   // no enable means no attenuation; otherwise ratchet up, drop only on recovery
   assign level_next = !att.enable ? 3'h0 :
                       raise ? att.target :
                       lower ? att.target : level_reg;

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         level_reg <= 3'h0;
      else
         level_reg <= level_next;
   end
   assign att.level = level_reg;

   // the level seen now was decided by last cycle's enable and recovery bits
   a_no_drop_norec: assert property (@(posedge mclk) disable iff (!nrst)
      $past(att.enable) && !$past(att.recover) |-> level_reg >= $past(level_reg))
      else $error("attenuation dropped without recovery");
endmodule
`default_nettype wire

// ---- verilog/ppc_config_bank.sv ----
// ppc_config_bank: playback protection, mixer and mask configuration registers
//
// How it works
// - limiter enable at 0x2B bit 7, reset zero; clear means no attenuation.
// - source clear: attenuation from pin and 3-bit code, 6 dB per step.
// - without recovery, applied attenuation only holds or rises.
// - with recovery, attenuation falls when pin is zero or battery recovered.
// - four mixer enables at 0x2C bits 7..4, reset disabled.
// - distortion limiter enable at 0x2D bit 7, reset disabled.
// - battery guard bit 6 and thermal foldback bit 5, reset zero.
// - signal generators one and two at bits 3 and 2, reset disabled.
// - bit 1 routes supply samples to limiter, guard and compressor.
// - undervoltage enable shuts playback below threshold at 0x2E, reset 0xBF.
// - threshold code is compared with the top 8 sample bits, whatever the supply sample selection.
// - mask 0x2F: clock error bit 7, pll lock bit 6, reset masked.
// - reserved bits read zero; writes to them are dropped.
// - events latched in read-only status at 0x34, self clearing on read.
`timescale 1ns/1ps
`default_nettype none
module ppc_config_bank
#(
   parameter int SAR_W = 8
)
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWdata,
   output logic [7:0] regRdata,
   input wire logic attnPin,
   input wire logic [SAR_W-1:0] sarSample,
   input wire logic sarValid,
   input wire logic clockErrorEvt,
   input wire logic pllLockEvt,
   output logic limiterActive,
   output logic [2:0] appliedAttn,
   output logic [7:0] mixEnables,
   output logic [7:0] featureEnables,
   output logic supplySampleToDsp,
   output logic playbackShutdown,
   output logic irqOut
);
   // ---------------------------------------------------------------
   // register file
   // ---------------------------------------------------------------
   logic [7:0] limiter_reg;
   logic [7:0] mixer_reg;
   logic [7:0] feature_reg;
   logic [7:0] uvthr_reg;
   logic [7:0] mask_reg;
   logic [7:0] latch_reg;
   logic [7:0] latch_next;
   logic [7:0] rdata_next;
   logic [SAR_W-1:0] sarHold_reg;
   logic [2:0] sarAttn_reg;
   logic uvTrip_reg;

   wire logic selLimiter = regAddr == ppc_pkg::OFS_LIMITER;
   wire logic selMixer = regAddr == ppc_pkg::OFS_MIXER;
   wire logic selFeature = regAddr == ppc_pkg::OFS_FEATURE;
   wire logic selUvthr = regAddr == ppc_pkg::OFS_UVTHR;
   wire logic selMask = regAddr == ppc_pkg::OFS_MASK0;
   wire logic selLatch = regAddr == ppc_pkg::OFS_LATCH0;

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         limiter_reg <= ppc_pkg::RST_LIMITER;
         mixer_reg <= ppc_pkg::RST_MIXER;
         feature_reg <= ppc_pkg::RST_FEATURE;
         uvthr_reg <= ppc_pkg::RST_UVTHR;
         mask_reg <= ppc_pkg::RST_MASK0;
      end
      else if (regWrite)
      begin
         // reserved bits never store, so they read as zero
         if (selLimiter)
            limiter_reg <= regWdata & ppc_pkg::WMASK_LIMITER;
         if (selMixer)
            mixer_reg <= regWdata & ppc_pkg::WMASK_MIXER;
         if (selFeature)
            feature_reg <= regWdata & ppc_pkg::WMASK_FEATURE;
         if (selUvthr)
            uvthr_reg <= regWdata;
         if (selMask)
            mask_reg <= regWdata & ppc_pkg::WMASK_MASK0;
      end
   end

   // ---------------------------------------------------------------
   // event latch and interrupt
   // ---------------------------------------------------------------
   wire logic [7:0] evtVec = {clockErrorEvt, pllLockEvt, 6'h00};
   // read clears, but an event in the same cycle wins
   assign latch_next = ((selLatch && regRead) ? 8'h00 : latch_reg) | evtVec;
   wire logic irqNext = |(latch_next & ~mask_reg);

   assign rdata_next = selLimiter ? limiter_reg :
                       selMixer ? mixer_reg :
                       selFeature ? feature_reg :
                       selUvthr ? uvthr_reg :
                       selMask ? mask_reg :
                       selLatch ? latch_reg : 8'h00;

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         latch_reg <= 8'h00;
         irqOut <= 1'b0;
         regRdata <= 8'h00;
      end
      else
      begin
         latch_reg <= latch_next;
         irqOut <= irqNext;
         if (regRead)
            regRdata <= rdata_next;
      end
   end

   // ---------------------------------------------------------------
   // attenuation source and tracking
   // ---------------------------------------------------------------
   // coarse lookup: lower supply sample gives more attenuation steps
   wire logic [2:0] sarLut = ppc_pkg::ATTN_MAX - sarHold_reg[SAR_W-1 -: 3];
   wire logic srcAnalog = limiter_reg[ppc_pkg::BIT_ATTN_SRC];
   wire logic [2:0] pinAttn = attnPin ? limiter_reg[ppc_pkg::BIT_ATTN_LSB +: 3] : 3'h0;
   ppc_attn_if attIf ();
   assign attIf.enable = limiter_reg[ppc_pkg::BIT_LIM_EN];
   assign attIf.recover = limiter_reg[ppc_pkg::BIT_RECOVER];
   assign attIf.target = srcAnalog ? sarAttn_reg : pinAttn;
   // battery recovered means the mapped target fell; pin zero is a release too
   assign attIf.release_req = srcAnalog ? 1'b1 : !attnPin;

   ppc_attn_track u_track
   (
      .mclk(mclk),
      .nrst(nrst),
      .att(attIf)
   );

   // ---------------------------------------------------------------
   // undervoltage and feature outputs
   // ---------------------------------------------------------------
   // threshold code compared against sample scaled to 8 bits; same scaling for either select
   wire logic [7:0] sar8 = sarHold_reg[SAR_W-1 -: 8];
   wire logic uvNext = feature_reg[ppc_pkg::BIT_UV_EN] && (sar8 < uvthr_reg);

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         sarHold_reg <= '0;
         sarAttn_reg <= 3'h0;
         uvTrip_reg <= 1'b0;
         limiterActive <= 1'b0;
         appliedAttn <= 3'h0;
         mixEnables <= 8'h00;
         featureEnables <= 8'h00;
         supplySampleToDsp <= 1'b0;
         playbackShutdown <= 1'b0;
      end
      else
      begin
         if (sarValid)
            sarHold_reg <= sarSample;
         sarAttn_reg <= sarLut;
         uvTrip_reg <= uvNext;
         limiterActive <= attIf.enable;
         appliedAttn <= attIf.level;
         mixEnables <= mixer_reg;
         featureEnables <= feature_reg;
         supplySampleToDsp <= feature_reg[ppc_pkg::BIT_SUPPLY_SEL];
         playbackShutdown <= uvTrip_reg;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   a_no_attn_off: assert property (@(posedge mclk) disable iff (!nrst)
      !limiter_reg[ppc_pkg::BIT_LIM_EN] ##2 1'b1 |-> appliedAttn == 3'h0 || $past(attIf.enable))
      else $error("attenuation applied while limiter off");
   a_reserved_zero: assert property (@(posedge mclk) disable iff (!nrst)
      (limiter_reg[1:0] == 2'h0) && (mixer_reg[3:0] == 4'h0) && !feature_reg[4]
      && (mask_reg[5:0] == 6'h00))
      else $error("reserved bit stored");
   a_mixer_write: assert property (@(posedge mclk) disable iff (!nrst)
      regWrite && selMixer |=> mixer_reg == ($past(regWdata) & 8'hf0))
      else $error("mixer register not updated");
   a_event_latched: assert property (@(posedge mclk) disable iff (!nrst)
      clockErrorEvt |=> latch_reg[ppc_pkg::BIT_IRQ_CLK])
      else $error("clock error event lost");
   a_masked_quiet: assert property (@(posedge mclk) disable iff (!nrst)
      (latch_next & ~mask_reg) == 8'h00 |=> !irqOut)
      else $error("masked event raised interrupt");
   a_unmasked_irq: assert property (@(posedge mclk) disable iff (!nrst)
      (latch_next & ~mask_reg) != 8'h00 |=> irqOut)
      else $error("unmasked event did not raise interrupt");
   a_read_clears: assert property (@(posedge mclk) disable iff (!nrst)
      regRead && selLatch && !clockErrorEvt && !pllLockEvt |=> latch_reg == 8'h00)
      else $error("latch not cleared by read");
   a_uv_shutdown: assert property (@(posedge mclk) disable iff (!nrst)
      uvNext |-> ##2 playbackShutdown)
      else $error("undervoltage did not shut playback");
   a_pin_target: assert property (@(posedge mclk) disable iff (!nrst)
      !srcAnalog && !attnPin |-> attIf.target == 3'h0)
      else $error("pin zero must request no attenuation");
   a_supply_sel: assert property (@(posedge mclk) disable iff (!nrst)
      feature_reg[ppc_pkg::BIT_SUPPLY_SEL] |=> supplySampleToDsp)
      else $error("supply select not forwarded");

   c_irq_raised: cover property (@(posedge mclk) disable iff (!nrst) $rose(irqOut));
   c_latch_read: cover property (@(posedge mclk) disable iff (!nrst) regRead && selLatch);
   c_attn_max: cover property (@(posedge mclk) disable iff (!nrst) appliedAttn == 3'h7);
   c_shutdown: cover property (@(posedge mclk) disable iff (!nrst) $rose(playbackShutdown));
endmodule
`default_nettype wire

// ---- verilog/ppc_pkg.sv ----
// ppc_pkg: constants for the playback protection configuration bank
package ppc_pkg;
   // ---------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_LIMITER = 8'h2b;
   localparam logic [7:0] OFS_MIXER = 8'h2c;
   localparam logic [7:0] OFS_FEATURE = 8'h2d;
   localparam logic [7:0] OFS_UVTHR = 8'h2e;
   localparam logic [7:0] OFS_MASK0 = 8'h2f;
   localparam logic [7:0] OFS_LATCH0 = 8'h34;
   // ---------------------------------------------------------------
   // reset values and writable bit masks
   // ---------------------------------------------------------------
   localparam logic [7:0] RST_LIMITER = 8'h00;
   localparam logic [7:0] RST_MIXER = 8'h00;
   localparam logic [7:0] RST_FEATURE = 8'h00;
   localparam logic [7:0] RST_UVTHR = 8'hbf;
   localparam logic [7:0] RST_MASK0 = 8'hc0;
   localparam logic [7:0] WMASK_LIMITER = 8'hfc;
   localparam logic [7:0] WMASK_MIXER = 8'hf0;
   localparam logic [7:0] WMASK_FEATURE = 8'hef;
   localparam logic [7:0] WMASK_UVTHR = 8'hff;
   localparam logic [7:0] WMASK_MASK0 = 8'hc0;
   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int BIT_LIM_EN = 7;
   localparam int BIT_ATTN_LSB = 4;
   localparam int BIT_ATTN_SRC = 3;
   localparam int BIT_RECOVER = 2;
   localparam int BIT_MIX_SERIAL = 7;
   localparam int BIT_MIX_SIDE = 6;
   localparam int BIT_MIX_REC = 5;
   localparam int BIT_MIX_LOOP = 4;
   localparam int BIT_DIST_EN = 7;
   localparam int BIT_GUARD_EN = 6;
   localparam int BIT_THERM_EN = 5;
   localparam int BIT_GEN1_EN = 3;
   localparam int BIT_GEN2_EN = 2;
   localparam int BIT_SUPPLY_SEL = 1;
   localparam int BIT_UV_EN = 0;
   localparam int BIT_IRQ_CLK = 7;
   localparam int BIT_IRQ_PLL = 6;
   // attenuation step per code, in dB
   localparam int ATTN_STEP_DB = 6;
   localparam logic [2:0] ATTN_MAX = 3'h7;
endpackage
